// ===== serial_eeprom_command_controller.sv
// serial_eeprom_command_controller: axi4-lite register front end that runs
// serial eeprom commands; assumes one clock and a pulled data line.
module serial_eeprom_command_controller
   import rom_ctl_pkg::*;
#(
   parameter int unsigned TMO_CYC = rom_ctl_pkg::TMO_CYCLES
) (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // axi4-lite write address
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   // axi4-lite write data
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   // axi4-lite write response
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // axi4-lite read address
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   // axi4-lite read data
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // serial eeprom pins
   output logic             o_rom_cs,
   output logic             o_rom_sk,
   output logic             o_rom_dio,
   output logic             o_rom_dio_oe_n,
   input  wire logic        i_rom_dio
);
   import rom_ctl_pkg::*;

   typedef struct packed {
      logic        aw_ok;
      logic        w_ok;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [7:0]  addr;
      logic [7:0]  data;
      cmd_e        code;
      logic        tout;
      logic        loaded;
      logic        pend;
      logic        auto;
   } ctl_s;

   ctl_s        q;
   ctl_s        d;
   logic        busy_w;
   logic [31:0] cmd_rd;
   logic [31:0] rd_mux;
   logic        rd_hit;
   logic        wr_hit;

   rom_cmd_if cif ();

   rom_command_engine #(
      .TMO_CYC (TMO_CYC)
   ) u_engine (
      .i_mclk         (i_mclk),
      .i_rst_n        (i_rst_n),
      .cmd            (cif.engine),
      .o_rom_cs       (o_rom_cs),
      .o_rom_sk       (o_rom_sk),
      .o_rom_dio      (o_rom_dio),
      .o_rom_dio_oe_n (o_rom_dio_oe_n),
      .i_rom_dio      (i_rom_dio)
   );

   assign busy_w    = q.pend || cif.busy;
   assign cif.start = q.pend && !cif.busy;
   assign cif.code  = q.code;
   assign cif.addr  = q.addr;
   assign cif.wdata = q.data;

   // handshake outputs
   assign o_awready = !q.aw_ok && !q.bvalid;
   assign o_wready  = !q.w_ok && !q.bvalid;
   assign o_arready = !q.rvalid;
   assign o_bvalid  = q.bvalid;
   assign o_bresp   = q.bresp;
   assign o_rvalid  = q.rvalid;
   assign o_rresp   = q.rresp;
   assign o_rdata   = q.rdata;

   // register read view
   always_comb begin
      cmd_rd                     = 32'h0000_0000;
      cmd_rd[BUSY_BIT]           = busy_w;
      cmd_rd[CMD_LSB +: 3]       = q.code;
      cmd_rd[TMO_BIT]            = q.tout;
      cmd_rd[LOADED_BIT]         = q.loaded;
      cmd_rd[ADDR_LSB +: 8]      = q.addr;
      rd_hit                     = 1'b1;
      case (i_araddr)
         CMD_OFS: begin
            rd_mux = cmd_rd;
         end
         DATA_OFS: begin
            rd_mux = {24'h00_0000, q.data};
         end
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   assign wr_hit = (q.awaddr == CMD_OFS) || (q.awaddr == DATA_OFS);

   always_comb begin
      d = q;
      // write channels taken in either order
      if (i_awvalid && o_awready) begin
         d.aw_ok  = 1'b1;
         d.awaddr = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         d.w_ok  = 1'b1;
         d.wdata = i_wdata;
         d.wstrb = i_wstrb;
      end
      if (q.bvalid && i_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_ok && q.w_ok) begin
         d.aw_ok  = 1'b0;
         d.w_ok   = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
         // fields are frozen while a command runs
         if (!busy_w && !q.auto) begin
            if (q.awaddr == CMD_OFS) begin
               if (q.wstrb[0]) begin
                  d.addr = q.wdata[ADDR_LSB +: 8];
               end
               if (q.wstrb[3] && q.wdata[BUSY_BIT]) begin
                  d.code = cmd_e'(q.wdata[CMD_LSB +: 3]);
                  d.pend = 1'b1;
               end
            end
            if ((q.awaddr == DATA_OFS) && q.wstrb[0]) begin
               d.data = q.wdata[7:0];
            end
         end
      end
      // read channel, one cycle latency
      if (q.rvalid && i_rready) begin
         d.rvalid = 1'b0;
      end
      if (i_arvalid && o_arready) begin
         d.rvalid = 1'b1;
         d.rdata  = rd_mux;
         d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (q.auto && !busy_w) begin
         d.auto = 1'b0;
         d.code = CMD_RELOAD;
         d.pend = 1'b1;
      end
      // launch clears stale status
      if (cif.start) begin
         d.pend = 1'b0;
         d.tout = 1'b0;
         if (q.code == CMD_RELOAD) begin
            d.loaded = 1'b0;
         end
      end
      if (cif.done) begin
         if (cif.timed_out) begin
            d.tout = 1'b1;
         end else if (q.code == CMD_READ) begin
            d.data = cif.rdata;
         end else if (q.code == CMD_RELOAD) begin
            d.loaded = (cif.rdata == SIG_BYTE);
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         q <= '{addr: ADDR_RST, data: DATA_RST, code: CMD_READ, bresp: RESP_OKAY,
                rresp: RESP_OKAY, auto: 1'b1, default: '0};
      end else begin
         q <= d;
      end
   end

   sequence s_cmd_write;
      q.aw_ok && q.w_ok && !busy_w && !q.auto && (q.awaddr == CMD_OFS);
   endsequence

   property p_tmo_flag;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (cif.done && cif.timed_out) |=> q.tout && !busy_w;
   endproperty
   a_tmo_flag: assert property (p_tmo_flag) else $error("time-out flag not set");

   property p_loaded;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (cif.done && !cif.timed_out && (q.code == CMD_RELOAD) && (cif.rdata == SIG_BYTE))
         |=> q.loaded;
   endproperty
   a_loaded: assert property (p_loaded) else $error("load flag not set");

   property p_addr_field;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (s_cmd_write and q.wstrb[0]) |=> (q.addr == $past(q.wdata[7:0]));
   endproperty
   a_addr_field: assert property (p_addr_field) else $error("address not stored");

   property p_data_read;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_arvalid && o_arready && (i_araddr == DATA_OFS))
         |=> (o_rdata[31:8] == 24'h00_0000) && (o_rdata[7:0] == $past(q.data)) && o_rvalid;
   endproperty
   a_data_read: assert property (p_data_read) else $error("bad data read");

   property p_busy_end;
      @(posedge i_mclk) disable iff (!i_rst_n)
      $fell(busy_w) |-> $past(cif.done);
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy dropped early");
endmodule // serial_eeprom_command_controller

// ===== rom_ctl_pkg.sv
// rom_ctl_pkg: constants, register map and command codes for the
// serial eeprom command controller; assumes a 25 MHz system clock.
package rom_ctl_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned TMO_MS      = 30;
   localparam int unsigned TMO_CYCLES  = TMO_MS * (CLK_HZ / 1000);
   localparam logic [7:0]  SK_HALF     = 8'h04;
   // register byte offsets
   localparam logic [7:0]  CMD_OFS     = 8'h00;
   localparam logic [7:0]  DATA_OFS    = 8'h04;
   // command register fields
   localparam int          BUSY_BIT    = 31;
   localparam int          CMD_LSB     = 28;
   localparam int          TMO_BIT     = 9;
   localparam int          LOADED_BIT  = 8;
   localparam int          ADDR_LSB    = 0;
   // reset values
   localparam logic [7:0]  ADDR_RST    = 8'h00;
   localparam logic [7:0]  DATA_RST    = 8'h00;
   // signature byte at location 0 that marks a valid device
   localparam logic [7:0]  SIG_BYTE    = 8'hA5;
   // axi responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // serial frame
   localparam logic [1:0]  OP_READ     = 2'h2;
   localparam logic [1:0]  OP_WRITE    = 2'h1;
   localparam logic [1:0]  OP_ERASE    = 2'h3;
   localparam logic [1:0]  OP_EXT      = 2'h0;
   localparam logic [7:0]  AP_ERASE_WRITE_ENABLE_CMD     = 8'hC0;
   localparam logic [7:0]  AP_EWDS     = 8'h00;
   localparam logic [7:0]  AP_WRITE_ALL_CMD     = 8'h40;
   localparam logic [7:0]  AP_ERASE_ALL_CMD     = 8'h80;
   localparam logic [4:0]  FRAME_SHORT = 5'h0B;
   localparam logic [4:0]  FRAME_LONG  = 5'h13;
   // commands
   typedef enum logic [2:0] {
      CMD_READ   = 3'b000,
      CMD_EWDS   = 3'b001,
      CMD_ERASE_WRITE_ENABLE_CMD   = 3'b010,
      CMD_WRITE  = 3'b011,
      CMD_WRITE_ALL_CMD   = 3'b100,
      CMD_ERASE  = 3'b101,
      CMD_ERASE_ALL_CMD   = 3'b110,
      CMD_RELOAD = 3'b111
   } cmd_e;
endpackage

// ===== rom_cmd_if.sv
// rom_cmd_if: command handoff between register front end and serial engine.
// assumes one clock; start is a one-cycle request taken only while idle.
interface rom_cmd_if;
   import rom_ctl_pkg::*;
   logic       start;
   cmd_e       code;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       busy;
   logic       done;
   logic       timed_out;
   logic [7:0] rdata;
   modport ctrl   (output start, code, addr, wdata,
                   input  busy, done, timed_out, rdata);
   modport engine (input  start, code, addr, wdata,
                   output busy, done, timed_out, rdata);
endinterface

// ===== rom_command_engine.sv
// rom_command_engine: serial frame generator and ready poll with time-out.
// assumes the data line has a pull; inputs are synchronous to i_mclk.
module rom_command_engine
   import rom_ctl_pkg::*;
#(
   parameter int unsigned TMO_CYC = rom_ctl_pkg::TMO_CYCLES
) (
   // clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   // command handoff
   rom_cmd_if.engine cmd,
   // serial pins
   output logic      o_rom_cs,
   output logic      o_rom_sk,
   output logic      o_rom_dio,
   output logic      o_rom_dio_oe_n,
   input  wire logic i_rom_dio
);
   localparam int TW = $clog2(TMO_CYC + 1);

   typedef enum logic [2:0] {
      E_IDLE  = 3'b000,
      E_SHIFT = 3'b001,
      E_GAP   = 3'b010,
      E_POLL  = 3'b011,
      E_DONE  = 3'b100
   } eng_st_e;

   typedef struct packed {
      eng_st_e       st;
      logic          cs;
      logic          sk;
      logic [18:0]   sh;
      logic [7:0]    rx;
      logic [4:0]    bitn;
      logic [4:0]    nbits;
      logic          rd;
      logic          poll;
      logic [7:0]    div;
      logic [TW-1:0] tmo;
      logic          tout;
   } eng_s;

   eng_s       q;
   eng_s       d;
   logic       tick;
   logic [1:0] op;
   logic [7:0] ab;
   logic       is_wr;
   logic       is_rd;

   always_comb begin
      op    = OP_READ;
      ab    = cmd.addr;
      is_wr = 1'b0;
      is_rd = 1'b0;
      case (cmd.code)
         CMD_READ: begin
            is_rd = 1'b1;
         end
         CMD_WRITE: begin
            op    = OP_WRITE;
            is_wr = 1'b1;
         end
         CMD_ERASE: begin
            op    = OP_ERASE;
            is_wr = 1'b1;
         end
         CMD_ERASE_WRITE_ENABLE_CMD: begin
            op = OP_EXT;
            ab = AP_ERASE_WRITE_ENABLE_CMD;
         end
         CMD_EWDS: begin
            op = OP_EXT;
            ab = AP_EWDS;
         end
         CMD_WRITE_ALL_CMD: begin
            op    = OP_EXT;
            ab    = AP_WRITE_ALL_CMD;
            is_wr = 1'b1;
         end
         CMD_ERASE_ALL_CMD: begin
            op    = OP_EXT;
            ab    = AP_ERASE_ALL_CMD;
            is_wr = 1'b1;
         end
         CMD_RELOAD: begin
            ab    = ADDR_RST;
            is_rd = 1'b1;
         end
         default: begin
            op = OP_READ;
         end
      endcase
   end

   always_comb begin
      d     = q;
      tick  = (q.div == SK_HALF - 8'h01);
      d.div = tick ? 8'h00 : q.div + 8'h01;
      case (q.st)
         E_IDLE: begin
            if (cmd.start) begin
               d.st    = E_SHIFT;
               d.cs    = 1'b1;
               d.sk    = 1'b0;
               d.bitn  = 5'h00;
               d.div   = 8'h00;
               d.tout  = 1'b0;
               d.rx    = 8'h00;
               d.rd    = is_rd;
               d.poll  = is_wr;
               d.nbits = (is_rd || (cmd.code == CMD_WRITE) || (cmd.code == CMD_WRITE_ALL_CMD))
                         ? FRAME_LONG : FRAME_SHORT;
               d.sh    = {1'b1, op, ab, cmd.wdata};
            end
         end
         E_SHIFT: begin
            if (tick && !q.sk) begin
               d.sk = 1'b1;
               if (q.rd && (q.bitn >= FRAME_SHORT)) begin
                  d.rx = {q.rx[6:0], i_rom_dio};
               end
            end else if (tick) begin
               d.sk   = 1'b0;
               d.sh   = {q.sh[17:0], 1'b0};
               d.bitn = q.bitn + 5'h01;
               if (q.bitn == q.nbits - 5'h01) begin
                  d.cs = 1'b0;
                  d.st = q.poll ? E_GAP : E_DONE;
               end
            end
         end
         E_GAP: begin
            if (tick) begin
               d.cs  = 1'b1;
               d.tmo = '0;
               d.st  = E_POLL;
            end
         end
         E_POLL: begin
            if (i_rom_dio) begin
               d.cs = 1'b0;
               d.st = E_DONE;
            end else if (q.tmo == TW'(TMO_CYC - 1)) begin
               d.tout = 1'b1;
               d.cs   = 1'b0;
               d.st   = E_DONE;
            end else begin
               d.tmo = q.tmo + 1'b1;
            end
         end
         E_DONE: begin
            d.st = E_IDLE;
         end
         default: begin
            d.st = E_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         q <= '{st: E_IDLE, nbits: FRAME_SHORT, tmo: '0, default: '0};
      end else begin
         q <= d;
      end
   end

   assign cmd.busy       = (q.st != E_IDLE);
   assign cmd.done       = (q.st == E_DONE);
   assign cmd.timed_out  = q.tout;
   assign cmd.rdata      = q.rx;
   assign o_rom_cs       = q.cs;
   assign o_rom_sk       = q.sk;
   assign o_rom_dio      = q.sh[18];
   assign o_rom_dio_oe_n = !((q.st == E_SHIFT) && !(q.rd && (q.bitn >= FRAME_SHORT)));

   sequence s_short_start;
      (q.st == E_IDLE) && cmd.start && (cmd.code inside {CMD_READ, CMD_EWDS,
                                                       CMD_ERASE_WRITE_ENABLE_CMD, CMD_RELOAD});
   endsequence

   property p_tmo_abort;
      @(posedge i_mclk) disable iff (!i_rst_n)
      ((q.st == E_POLL) && !i_rom_dio && (q.tmo == TW'(TMO_CYC - 1)))
         |=> ((q.st == E_DONE) && q.tout && !q.cs) ##1 (q.st == E_IDLE);
   endproperty
   a_tmo_abort: assert property (p_tmo_abort) else $error("time-out did not abort");

   property p_ready_high;
      @(posedge i_mclk) disable iff (!i_rst_n)
      ((q.st == E_POLL) && i_rom_dio) |=> ((q.st == E_DONE) && !q.tout);
   endproperty
   a_ready_high: assert property (p_ready_high) else $error("high line not done");

   property p_short_no_poll;
      @(posedge i_mclk) disable iff (!i_rst_n)
      s_short_start |=> !q.poll;
   endproperty
   a_short_no_poll: assert property (p_short_no_poll) else $error("poll armed");

   property p_gap_needs_poll;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (q.st == E_GAP) |-> q.poll;
   endproperty
   a_gap_needs_poll: assert property (p_gap_needs_poll) else $error("bad gap");

   property p_write_frame;
      @(posedge i_mclk) disable iff (!i_rst_n)
      ((q.st == E_IDLE) && cmd.start && (cmd.code == CMD_WRITE))
         |=> (q.sh[7:0] == $past(cmd.wdata)) && (q.sh[15:8] == $past(cmd.addr))
             && (q.nbits == FRAME_LONG);
   endproperty
   a_write_frame: assert property (p_write_frame) else $error("bad write frame");
endmodule // rom_command_engine

// ===== eeprom_model.sv
// eeprom_model: behavioural 256-byte serial eeprom on the far side.
// assumes the bench resolves the shared data line and its pull.
module eeprom_model
   import rom_ctl_pkg::*;
(
   // control
   input  wire logic i_mclk,
   input  wire logic i_present,
   input  wire logic i_slow,
   // serial pins
   input  wire logic i_cs,
   input  wire logic i_sk,
   input  wire logic i_di,
   output logic      o_do,
   output logic      o_do_en
);
   logic [7:0]  mem [256];
   logic [10:0] hdr;
   logic [18:0] sr;
   logic [7:0]  rbuf;
   logic        rbit;
   logic        wr_en;
   logic        poll;
   logic        rd;
   int          nbit;
   int          busy;
   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      {sr, hdr, rbuf, rbit, poll, rd} = '0;
      nbit = 0;
      busy = 0;
      wr_en = 1'b0;
   end
   // shift frame bits on sk rise
   always @(posedge i_sk) begin
      if (i_cs && !poll) begin
         sr = {sr[17:0], i_di};
         nbit++;
         if (nbit == 11) begin
            hdr = sr[10:0];
            rd = (sr[9:8] == OP_READ);
            rbuf = mem[sr[7:0]];
         end
      end
   end
   always @(negedge i_sk) begin
      if (rd) begin
         rbit = rbuf[7];
         rbuf = {rbuf[6:0], 1'b0};
      end
   end
   always @(posedge i_mclk) begin
      if (busy > 0) busy--;
   end
   assign o_do    = poll ? (busy == 0) : rbit;
   assign o_do_en = i_present && i_cs && (rd || poll);
   // frame ends on cs fall
   always @(negedge i_cs) begin
      if (poll) begin
         poll = 1'b0;
      end else if (i_present && !rd && (nbit == 11 || nbit == 19)) begin
         case (hdr[9:8])
            OP_WRITE: if (wr_en) mem[hdr[7:0]] = sr[7:0];
            OP_ERASE: if (wr_en) mem[hdr[7:0]] = 8'hFF;
            default: case (hdr[7:6])
               2'b11: wr_en = 1'b1;
               2'b00: wr_en = 1'b0;
               2'b01: if (wr_en) foreach (mem[i]) mem[i] = sr[7:0];
               default: if (wr_en) foreach (mem[i]) mem[i] = 8'hFF;
            endcase
         endcase
         poll = !(hdr[9:8] == OP_EXT && hdr[6] == hdr[7]);
         busy = (poll && wr_en) ? (i_slow ? 60 : 6) : 0;
      end
      nbit = 0;
      rd = 1'b0;
   end
endmodule // eeprom_model

// ===== serial_eeprom_command_controller_tb_top.sv
// serial_eeprom_command_controller_tb_top: self-checking bench.
// assumes the eeprom model and a pulled data line at the pin.
module serial_eeprom_command_controller_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import rom_ctl_pkg::*;
   localparam int TMO = 200;
   logic        mclk = 1'b0;
   logic        rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic        present, slow, pull_hi;
   logic [7:0]  awaddr, araddr, a, v;
   logic [31:0] wdata, d, rdata;
   logic [1:0]  bresp, rresp, r;
   wire         awready, wready, bvalid, arready, rvalid;
   wire         cs, sk, dout, oe_n, m_do, m_en, dio;
   int          error_cnt, compares, seed, cyc, t, el;
   bit          exp;
   assign dio = !oe_n ? dout : (m_en ? m_do : pull_hi);
   always #20 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   serial_eeprom_command_controller #(.TMO_CYC(TMO)) dut (
      .i_mclk(mclk), .i_rst_n(rst_n),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .o_rom_cs(cs), .o_rom_sk(sk), .o_rom_dio(dout), .o_rom_dio_oe_n(oe_n),
      .i_rom_dio(dio));
   eeprom_model model (
      .i_mclk(mclk), .i_present(present), .i_slow(slow), .i_cs(cs),
      .i_sk(sk), .i_di(dout), .o_do(m_do), .o_do_en(m_en));
   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      compares++;
      if (seen !== expv) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, expv);
      end
   endtask
   task automatic axw(input logic [7:0] ad, input logic [31:0] dv, input logic [1:0] er);
      logic aw_t, w_t, b_t;
      int   n;
      @(posedge mclk);
      n = 0;
      b_t = 1'b0;
      awaddr <= ad;
      wdata <= dv;
      {awvalid, wvalid, bready} <= 3'b111;
      while (!b_t && n < 200) begin
         @(negedge mclk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bready && bvalid;
         if (b_t) chk(bresp, er);
         @(posedge mclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (b_t) bready <= 1'b0;
         n++;
      end
      if (!b_t) chk(32'h0, 32'h1);
   endtask
   task automatic axr(input logic [7:0] ad, output logic [31:0] dv, output logic [1:0] rv);
      logic ar_t, r_t;
      int   n;
      @(posedge mclk);
      n = 0;
      r_t = 1'b0;
      araddr <= ad;
      {arvalid, rready} <= 2'b11;
      while (!r_t && n < 200) begin
         @(negedge mclk);
         ar_t = arvalid && arready;
         r_t = rready && rvalid;
         dv = rdata;
         rv = rresp;
         @(posedge mclk);
         if (ar_t) arvalid <= 1'b0;
         if (r_t) rready <= 1'b0;
         n++;
      end
      if (!r_t) chk(32'h0, 32'h1);
   endtask
   task automatic idle(output logic [31:0] dv);
      int n;
      n = 0;
      dv = 32'hFFFF_FFFF;
      while (dv[BUSY_BIT] !== 1'b0 && n < 3000) begin
         axr(CMD_OFS, dv, r);
         n++;
      end
      if (n >= 3000) chk(32'h0, 32'h1);
   endtask
   task automatic cmd(input cmd_e c, input logic [7:0] ad);
      axw(CMD_OFS, {1'b1, c, 20'h0, ad}, RESP_OKAY);
      axr(CMD_OFS, d, r);
      chk(d[BUSY_BIT], 1'b1);
      idle(d);
   endtask
   task automatic rd_loc(input logic [7:0] ad, input logic [7:0] ev);
      cmd(CMD_READ, ad);
      axr(DATA_OFS, d, r);
      chk(d, {24'h0, ev});
   endtask
   task automatic wr_loc(input logic [7:0] ad, input logic [7:0] dv);
      axw(DATA_OFS, {24'h0, dv}, RESP_OKAY);
      cmd(CMD_WRITE, ad);
   endtask
   task automatic summarize;
      $display("error_cnt %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      summarize();
   end
   initial begin
      seed = 32'hE9B7;
      {rst_n, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
      {present, pull_hi} = 2'b11;
      {awaddr, araddr, wdata} = '0;
      {error_cnt, compares, cyc} = '0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      axr(DATA_OFS, d, r);
      chk(d, {24'h0, DATA_RST});
      idle(d);
      chk(d[9:0], {2'b00, ADDR_RST});
      axw(8'h08, 32'h0, RESP_SLVERR);
      axr(8'h08, d, r);
      chk(r, RESP_SLVERR);
      axw(DATA_OFS, 32'hFFFF_FFFF, RESP_OKAY);
      axr(DATA_OFS, d, r);
      chk(d, 32'h0000_00FF);
      axw(CMD_OFS, 32'h0000_035C, RESP_OKAY);
      axr(CMD_OFS, d, r);
      chk(d[9:0], 10'h05C);
      wr_loc(8'h10, 8'h3C);
      rd_loc(8'h10, 8'hFF);
      cmd(CMD_ERASE_WRITE_ENABLE_CMD, 8'hC0);
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : 8'($random(seed));
         v = 8'($random(seed));
         slow = i[0];
         wr_loc(a, v);
         axr(CMD_OFS, d, r);
         chk({d[TMO_BIT], d[7:0]}, {1'b0, a});
         rd_loc(a, v);
      end
      wr_loc(8'h00, SIG_BYTE);
      cmd(CMD_RELOAD, 8'h00);
      chk(d[LOADED_BIT], 1'b1);
      cmd(CMD_ERASE, a);
      rd_loc(a, 8'hFF);
      axw(DATA_OFS, 32'h5A, RESP_OKAY);
      cmd(CMD_WRITE_ALL_CMD, 8'h00);
      rd_loc(8'($random(seed)), 8'h5A);
      cmd(CMD_ERASE_ALL_CMD, 8'h00);
      rd_loc(8'($random(seed)), 8'hFF);
      cmd(CMD_EWDS, 8'h00);
      wr_loc(8'h07, 8'h12);
      rd_loc(8'h07, 8'hFF);
      present = 1'b0;
      for (int p = 0; p < 2; p++) begin
         pull_hi = p[0];
         for (int c = 0; c < 8; c++) begin
            exp = !pull_hi && c >= 3 && c <= 6;
            t = cyc;
            cmd(cmd_e'(c), 8'h20);
            el = cyc - t;
            chk(d[TMO_BIT], exp);
            if (exp) chk(el >= TMO && el < TMO + 600, 1'b1);
         end
      end
      summarize();
   end
endmodule // serial_eeprom_command_controller_tb_top
